// ### core/csc_pkg.sv
package csc_pkg;

	// Widths of the status and control datapath
	localparam int unsigned DATA_W = 32;
	localparam int unsigned EXC_W  = 6;
	localparam int unsigned SEL_W  = 8;
	localparam int unsigned FLAG_W = 4;
	localparam int unsigned CTRL_W = 2;
	localparam int unsigned NUM_CODES = 64;

	// Field positions inside the combined status word and the mask and control registers
	localparam int unsigned FLAG_LSB  = 28;
	localparam int unsigned FLAG_MSB  = 31;
	localparam int unsigned TBIT_POS  = 24;
	localparam int unsigned EXC_LSB   = 0;
	localparam int unsigned EXC_MSB   = 5;
	localparam int unsigned PM_POS    = 0;
	localparam int unsigned THREAD_UNPRIVILEGED_POS = 0;
	localparam int unsigned STACK_SELECT_POS = 1;

	// Register name codes carried by the special register instructions
	typedef logic [SEL_W-1:0] csc_sel_t;
	localparam csc_sel_t SEL_FLAGS       = 8'h00;
	localparam csc_sel_t SEL_EXC_FLAGS   = 8'h01;
	localparam csc_sel_t SEL_STATE_FLAGS = 8'h02;
	localparam csc_sel_t SEL_COMBINED    = 8'h03;
	localparam csc_sel_t SEL_EXC         = 8'h05;
	localparam csc_sel_t SEL_STATE       = 8'h06;
	localparam csc_sel_t SEL_EXC_STATE   = 8'h07;
	localparam csc_sel_t SEL_PRIORITY_MASK     = 8'h10;
	localparam csc_sel_t SEL_CONTROL     = 8'h14;

	// Exception numbers
	typedef logic [EXC_W-1:0] csc_exc_t;
	localparam csc_exc_t EXC_THREAD     = 6'h00;
	localparam csc_exc_t EXC_NMI        = 6'h02;
	localparam csc_exc_t EXC_HARD_FAULT = 6'h03;
	localparam csc_exc_t EXC_SUPERVISOR_CALL_EXCEPTION     = 6'h0B;
	localparam csc_exc_t EXC_PENDABLE_SERVICE_EXCEPTION     = 6'h0E;
	localparam csc_exc_t EXC_SYSTEM_TICK_EXCEPTION    = 6'h0F;
	localparam csc_exc_t EXC_IRQ_BASE   = 6'h10;
	localparam int unsigned MAX_IRQ     = 32;

	// Reset values
	localparam logic [DATA_W-1:0] ZERO_WORD   = 32'h0000_0000;
	localparam logic [FLAG_W-1:0] FLAGS_RST   = 4'h0;
	localparam logic              PM_RST      = 1'b0;
	localparam logic [CTRL_W-1:0] CONTROL_RST = 2'h0;
	localparam logic              TBIT_RST    = 1'b0;

endpackage : csc_pkg

// ### core/csc_exc_check.sv
`timescale 1ns/1ps
`default_nettype none

module csc_exc_check #(
	parameter bit          HAS_SYSTEM_TICK_EXCEPTION = 1'b1,
	parameter int unsigned NUM_IRQ     = 32
) (
	input  wire logic [csc_pkg::EXC_W-1:0] num,
	output logic                           legal
);

	logic [csc_pkg::NUM_CODES-1:0] code_ok;

	// One entry per code; the table folds to constants at elaboration.
	// Thread code is not an exception, so entering with it is refused.
	for (genvar i = 0; i < csc_pkg::NUM_CODES; i++)
	begin : g_code
		if (i == int'(csc_pkg::EXC_NMI) ||
			i == int'(csc_pkg::EXC_HARD_FAULT) ||
			i == int'(csc_pkg::EXC_SUPERVISOR_CALL_EXCEPTION) || i == int'(csc_pkg::EXC_PENDABLE_SERVICE_EXCEPTION))
		begin : g_fixed
			assign code_ok[i] = 1'b1;
		end
		else if (i == int'(csc_pkg::EXC_SYSTEM_TICK_EXCEPTION))
		begin : g_tick
			assign code_ok[i] = HAS_SYSTEM_TICK_EXCEPTION;
		end
		else if (i >= int'(csc_pkg::EXC_IRQ_BASE) &&
			i < int'(csc_pkg::EXC_IRQ_BASE) + int'(NUM_IRQ))
		begin : g_irq
			assign code_ok[i] = 1'b1;
		end
		else
		begin : g_rsvd
			assign code_ok[i] = 1'b0;
		end
	end

	assign legal = code_ok[num];

endmodule : csc_exc_check

`default_nettype wire

// ### core/csc_psr_view.sv
`timescale 1ns/1ps
`default_nettype none

module csc_psr_view (
	input  wire logic [csc_pkg::SEL_W-1:0]  sel,
	input  wire logic [csc_pkg::FLAG_W-1:0] flags,
	input  wire logic [csc_pkg::EXC_W-1:0]  exc_num,
	output logic [csc_pkg::DATA_W-1:0]      rdata,
	output logic                            is_status,
	output logic                            has_flags
);

	logic has_exc;

	// Which of the three fields each register name covers
	always_comb
	begin
		is_status = 1'b1;
		has_flags = 1'b0;
		has_exc   = 1'b0;
		if (sel == csc_pkg::SEL_FLAGS)
		begin
			has_flags = 1'b1;
		end
		else if (sel == csc_pkg::SEL_EXC_FLAGS || sel == csc_pkg::SEL_COMBINED)
		begin
			has_flags = 1'b1;
			has_exc   = 1'b1;
		end
		else if (sel == csc_pkg::SEL_STATE_FLAGS)
		begin
			has_flags = 1'b1;
		end
		else if (sel == csc_pkg::SEL_EXC || sel == csc_pkg::SEL_EXC_STATE)
		begin
			has_exc = 1'b1;
		end
		else if (sel == csc_pkg::SEL_STATE)
		begin
			has_exc = 1'b0;
		end
		else
		begin
			is_status = 1'b0;
		end
	end

	// State bit never shows here, reserved bits stay zero
	always_comb
	begin
		rdata = csc_pkg::ZERO_WORD;
		if (has_flags)
		begin
			rdata[csc_pkg::FLAG_MSB:csc_pkg::FLAG_LSB] = flags;
		end
		if (has_exc)
		begin
			rdata[csc_pkg::EXC_MSB:csc_pkg::EXC_LSB] = exc_num;
		end
	end

endmodule : csc_psr_view

`default_nettype wire

// ### core/csc_regs.sv
`timescale 1ns/1ps
`default_nettype none

module csc_regs #(
	parameter bit          HAS_SYSTEM_TICK_EXCEPTION = 1'b1,
	parameter bit          HAS_PRIV    = 1'b1,
	parameter int unsigned NUM_IRQ     = csc_pkg::MAX_IRQ,
	parameter bit          DATA_BIG    = 1'b0,
	parameter bit          MUL_32CYC   = 1'b1
) (
	input  wire logic                        CLK,
	input  wire logic                        NRST,
	input  wire logic                        SR_RD,
	input  wire logic                        SR_WR,
	input  wire logic [csc_pkg::SEL_W-1:0]   SR_SEL,
	input  wire logic [csc_pkg::DATA_W-1:0]  SR_WDATA,
	input  wire logic                        CPS_EN,
	input  wire logic                        CPS_MASK,
	input  wire logic                        FLAGS_WE,
	input  wire logic [csc_pkg::FLAG_W-1:0]  FLAGS_IN,
	input  wire logic                        RST_VEC_VALID,
	input  wire logic [csc_pkg::DATA_W-1:0]  RST_VEC_WORD,
	input  wire logic                        EXC_ENTRY,
	input  wire logic [csc_pkg::EXC_W-1:0]   EXC_ENTRY_NUM,
	input  wire logic                        EXC_VEC_BIT0,
	input  wire logic                        EXC_RETURN,
	input  wire logic                        RET_TO_THREAD,
	input  wire logic [csc_pkg::EXC_W-1:0]   RET_EXC_NUM,
	input  wire logic                        RET_STACK_SELECT,
	input  wire logic                        RET_STACKED_T,
	input  wire logic [csc_pkg::FLAG_W-1:0]  RET_STACKED_FLAGS,
	input  wire logic                        XCHG_BRANCH,
	input  wire logic                        XCHG_TARGET_BIT0,
	input  wire logic                        EXEC_ATTEMPT,
	input  wire logic                        MULTI_BUSY,
	input  wire logic                        MUL_BUSY,
	input  wire logic                        IRQ_TAKE,
	output logic [csc_pkg::DATA_W-1:0]       SR_RDATA,
	output logic                             SR_RVALID,
	output logic [csc_pkg::FLAG_W-1:0]       FLAGS,
	output logic [csc_pkg::EXC_W-1:0]        EXC_NUMBER,
	output logic                             TBIT,
	output logic [csc_pkg::DATA_W-1:0]       STACKED_PSR,
	output logic                             ENTRY_REJECT,
	output logic                             HANDLER_MODE,
	output logic                             PRIVILEGED,
	output logic                             SP_USE_PROCESS,
	output logic                             CFG_EXC_BLOCK,
	output logic                             FAULT_REQ,
	output logic                             LOCKUP,
	output logic                             ABANDON,
	output logic                             DATA_BIG_ENDIAN,
	output logic                             INSTR_BIG_ENDIAN
);

	// Architectural state
	logic [csc_pkg::FLAG_W-1:0] flags_q;
	logic [csc_pkg::FLAG_W-1:0] flags_d;
	logic [csc_pkg::EXC_W-1:0]  exc_q;
	logic [csc_pkg::EXC_W-1:0]  exc_d;
	logic                       tbit_q;
	logic                       tbit_d;
	logic                       pm_q;
	logic                       pm_d;
	logic                       stack_select_q;
	logic                       stack_select_d;
	logic                       thread_unprivileged_q;
	logic                       thread_unprivileged_d;
	logic                       lock_q;

	// Decode helpers
	logic [csc_pkg::DATA_W-1:0] view_rdata;
	logic                       view_status;
	logic                       view_flags;
	logic                       entry_legal;
	logic                       in_handler;
	logic                       is_priv;
	logic [csc_pkg::DATA_W-1:0] rd_word;
	logic [csc_pkg::DATA_W-1:0] full_psr;
	logic                       wr_priority_mask;
	logic                       wr_control;
	logic                       entry_ok;
	logic                       t_fault;

	csc_psr_view u_view (
		.sel       (SR_SEL),
		.flags     (flags_q),
		.exc_num   (exc_q),
		.rdata     (view_rdata),
		.is_status (view_status),
		.has_flags (view_flags)
	);

	csc_exc_check #(
		.HAS_SYSTEM_TICK_EXCEPTION (HAS_SYSTEM_TICK_EXCEPTION),
		.NUM_IRQ     (NUM_IRQ)
	) u_check (
		.num   (EXC_ENTRY_NUM),
		.legal (entry_legal)
	);

	// Mode and privilege seen by the instruction in flight
	assign in_handler = (exc_q != csc_pkg::EXC_THREAD);
	assign is_priv    = in_handler || !(thread_unprivileged_q && HAS_PRIV);
	assign entry_ok   = EXC_ENTRY && entry_legal;
	assign t_fault    = EXEC_ATTEMPT && !tbit_q;

	// Full word as it goes on the stack, state bit included
	always_comb
	begin
		full_psr = csc_pkg::ZERO_WORD;
		full_psr[csc_pkg::FLAG_MSB:csc_pkg::FLAG_LSB] = flags_q;
		full_psr[csc_pkg::TBIT_POS] = tbit_q;
		full_psr[csc_pkg::EXC_MSB:csc_pkg::EXC_LSB] = exc_q;
	end

	// Unprivileged code may not touch the mask or control registers
	assign wr_priority_mask = SR_WR && (SR_SEL == csc_pkg::SEL_PRIORITY_MASK) && is_priv;
	assign wr_control = SR_WR && (SR_SEL == csc_pkg::SEL_CONTROL) &&
		is_priv;

	// Read mux; unknown names answer zero
	always_comb
	begin
		rd_word = csc_pkg::ZERO_WORD;
		if (view_status)
		begin
			rd_word = view_rdata;
		end
		else if (SR_SEL == csc_pkg::SEL_PRIORITY_MASK)
		begin
			rd_word[csc_pkg::PM_POS] = pm_q;
		end
		else if (SR_SEL == csc_pkg::SEL_CONTROL)
		begin
			rd_word[csc_pkg::STACK_SELECT_POS] = stack_select_q && !in_handler;
			rd_word[csc_pkg::THREAD_UNPRIVILEGED_POS] = thread_unprivileged_q && HAS_PRIV;
		end
	end

	// Flags: hardware events outrank software and the ALU
	always_comb
	begin
		flags_d = flags_q;
		if (EXC_RETURN)
		begin
			flags_d = RET_STACKED_FLAGS;
		end
		else if (SR_WR && view_status && view_flags)
		begin
			flags_d = SR_WDATA[csc_pkg::FLAG_MSB:csc_pkg::FLAG_LSB];
		end
		else if (FLAGS_WE)
		begin
			flags_d = FLAGS_IN;
		end
	end

	// Exception number follows entry and return only; writes never land
	always_comb
	begin
		exc_d = exc_q;
		if (entry_ok)
		begin
			exc_d = EXC_ENTRY_NUM;
		end
		else if (EXC_RETURN)
		begin
			exc_d = RET_TO_THREAD ? csc_pkg::EXC_THREAD : RET_EXC_NUM;
		end
	end

	// State bit: loaded at reset fetch, cleared by the listed events only
	always_comb
	begin
		tbit_d = tbit_q;
		if (RST_VEC_VALID)
		begin
			tbit_d = RST_VEC_WORD[0];
		end
		else if (entry_ok)
		begin
			tbit_d = EXC_VEC_BIT0;
		end
		else if (EXC_RETURN)
		begin
			tbit_d = RET_STACKED_T;
		end
		else if (XCHG_BRANCH)
		begin
			tbit_d = XCHG_TARGET_BIT0;
		end
	end

	// Mask bit from the move or the interrupt-state change instruction
	always_comb
	begin
		pm_d = pm_q;
		if (CPS_EN && is_priv)
		begin
			pm_d = CPS_MASK;
		end
		else if (wr_priority_mask)
		begin
			pm_d = SR_WDATA[csc_pkg::PM_POS];
		end
	end

	// Control: entry and return take it over from software
	always_comb
	begin
		stack_select_d = stack_select_q;
		thread_unprivileged_d = thread_unprivileged_q;
		if (entry_ok)
		begin
			stack_select_d = 1'b0;
		end
		else if (EXC_RETURN)
		begin
			stack_select_d = RET_TO_THREAD ? RET_STACK_SELECT : 1'b0;
		end
		else if (wr_control)
		begin
			if (!in_handler)
			begin
				stack_select_d = SR_WDATA[csc_pkg::STACK_SELECT_POS];
			end
			thread_unprivileged_d = SR_WDATA[csc_pkg::THREAD_UNPRIVILEGED_POS] && HAS_PRIV;
		end
	end

	// Condition flags
	always_ff @(posedge CLK or negedge NRST)
	begin
		if (!NRST)
			flags_q <= csc_pkg::FLAGS_RST;
		else
			flags_q <= flags_d;
	end

	// Exception number and state bit; the bit waits for the vector fetch
	always_ff @(posedge CLK or negedge NRST)
	begin
		if (!NRST)
		begin
			exc_q  <= csc_pkg::EXC_THREAD;
			tbit_q <= csc_pkg::TBIT_RST;
		end
		else
		begin
			exc_q  <= exc_d;
			tbit_q <= tbit_d;
		end
	end

	// Mask and control
	always_ff @(posedge CLK or negedge NRST)
	begin
		if (!NRST)
		begin
			pm_q    <= csc_pkg::PM_RST;
			stack_select_q <= csc_pkg::CONTROL_RST[csc_pkg::STACK_SELECT_POS];
			thread_unprivileged_q <= csc_pkg::CONTROL_RST[csc_pkg::THREAD_UNPRIVILEGED_POS];
		end
		else
		begin
			pm_q    <= pm_d;
			stack_select_q <= stack_select_d;
			thread_unprivileged_q <= thread_unprivileged_d;
		end
	end

	// Read answer, one cycle after the strobe, taken before any write
	always_ff @(posedge CLK or negedge NRST)
	begin
		if (!NRST)
		begin
			SR_RDATA  <= csc_pkg::ZERO_WORD;
			SR_RVALID <= 1'b0;
		end
		else
		begin
			SR_RVALID <= SR_RD;
			if (SR_RD)
				SR_RDATA <= rd_word;
		end
	end

	// Registered copies of the state for the rest of the core
	always_ff @(posedge CLK or negedge NRST)
	begin
		if (!NRST)
		begin
			FLAGS          <= csc_pkg::FLAGS_RST;
			EXC_NUMBER     <= csc_pkg::EXC_THREAD;
			TBIT           <= csc_pkg::TBIT_RST;
			HANDLER_MODE   <= 1'b0;
			PRIVILEGED     <= 1'b1;
			SP_USE_PROCESS <= 1'b0;
			CFG_EXC_BLOCK  <= csc_pkg::PM_RST;
		end
		else
		begin
			FLAGS          <= flags_d;
			EXC_NUMBER     <= exc_d;
			TBIT           <= tbit_d;
			HANDLER_MODE   <= (exc_d != csc_pkg::EXC_THREAD);
			PRIVILEGED     <= (exc_d != csc_pkg::EXC_THREAD) ||
				!(thread_unprivileged_d && HAS_PRIV);
			SP_USE_PROCESS <= stack_select_d &&
				(exc_d == csc_pkg::EXC_THREAD);
			CFG_EXC_BLOCK  <= pm_d;
		end
	end

	// Word for the stack on entry; rejected codes leave state untouched
	always_ff @(posedge CLK or negedge NRST)
	begin
		if (!NRST)
		begin
			STACKED_PSR  <= csc_pkg::ZERO_WORD;
			ENTRY_REJECT <= 1'b0;
		end
		else
		begin
			ENTRY_REJECT <= EXC_ENTRY && !entry_legal;
			if (entry_ok)
				STACKED_PSR <= full_psr;
		end
	end

	// Bad state bit: fault normally, lockup if already in a top handler
	always_ff @(posedge CLK or negedge NRST)
	begin
		if (!NRST)
		begin
			FAULT_REQ <= 1'b0;
			lock_q    <= 1'b0;
		end
		else
		begin
			FAULT_REQ <= t_fault && !lock_q &&
				(exc_q != csc_pkg::EXC_NMI) &&
				(exc_q != csc_pkg::EXC_HARD_FAULT);
			if (t_fault && ((exc_q == csc_pkg::EXC_NMI) ||
				(exc_q == csc_pkg::EXC_HARD_FAULT)))
				lock_q <= 1'b1;
		end
	end

	// Lockup holds until reset; only reset clears it
	always_ff @(posedge CLK or negedge NRST)
	begin
		if (!NRST)
			LOCKUP <= 1'b0;
		else
			LOCKUP <= lock_q || (t_fault && ((exc_q == csc_pkg::EXC_NMI) ||
				(exc_q == csc_pkg::EXC_HARD_FAULT)));
	end

	// Abandon a multi-cycle instruction so it restarts after the handler
	always_ff @(posedge CLK or negedge NRST)
	begin
		if (!NRST)
			ABANDON <= 1'b0;
		else
			ABANDON <= IRQ_TAKE &&
				(MULTI_BUSY || (MUL_BUSY && MUL_32CYC));
	end

	// Byte order flags: instruction side is fixed little-endian
	always_ff @(posedge CLK or negedge NRST)
	begin
		if (!NRST)
		begin
			DATA_BIG_ENDIAN  <= 1'b0;
			INSTR_BIG_ENDIAN <= 1'b0;
		end
		else
		begin
			DATA_BIG_ENDIAN  <= DATA_BIG;
			INSTR_BIG_ENDIAN <= 1'b0;
		end
	end

endmodule : csc_regs

`default_nettype wire

// ### bench/csc_regs_sva.sv
`timescale 1ns/1ps
`default_nettype none

module csc_regs_sva #(
	parameter bit          HAS_SYSTEM_TICK_EXCEPTION = 1'b1,
	parameter int unsigned NUM_IRQ     = 32
) (
	input wire logic        CLK,
	input wire logic        NRST,
	input wire logic        SR_RD,
	input wire logic        SR_WR,
	input wire logic [7:0]  SR_SEL,
	input wire logic        CPS_EN,
	input wire logic        CPS_MASK,
	input wire logic        RST_VEC_VALID,
	input wire logic [31:0] RST_VEC_WORD,
	input wire logic        EXC_ENTRY,
	input wire logic [5:0]  EXC_ENTRY_NUM,
	input wire logic        EXC_RETURN,
	input wire logic        XCHG_BRANCH,
	input wire logic        XCHG_TARGET_BIT0,
	input wire logic        EXEC_ATTEMPT,
	input wire logic        MULTI_BUSY,
	input wire logic        MUL_BUSY,
	input wire logic        IRQ_TAKE,
	input wire logic [31:0] SR_RDATA,
	input wire logic        SR_RVALID,
	input wire logic [5:0]  EXC_NUMBER,
	input wire logic        TBIT,
	input wire logic        ENTRY_REJECT,
	input wire logic        HANDLER_MODE,
	input wire logic        PRIVILEGED,
	input wire logic        SP_USE_PROCESS,
	input wire logic        CFG_EXC_BLOCK,
	input wire logic        FAULT_REQ,
	input wire logic        LOCKUP,
	input wire logic        ABANDON,
	input wire logic        INSTR_BIG_ENDIAN
);
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!NRST);

	// Entry numbers the block must turn away, tracking the build options
	logic rsv_num;
	always_comb
	begin
		case (EXC_ENTRY_NUM)
			6'd2, 6'd3, 6'd11, 6'd14: rsv_num = 1'b0;
			6'd15: rsv_num = !HAS_SYSTEM_TICK_EXCEPTION;
			default: rsv_num = (EXC_ENTRY_NUM < 16) ||
				(EXC_ENTRY_NUM >= 16 + NUM_IRQ);
		endcase
	end

	sequence s_entry;
		EXC_ENTRY && !rsv_num;
	endsequence
	sequence s_unpriv_ctrl;
		SR_WR && SR_SEL == csc_pkg::SEL_CONTROL && !PRIVILEGED &&
			!HANDLER_MODE && !EXC_ENTRY && !EXC_RETURN;
	endsequence

	a_read_answer: assert property (SR_RD |=> SR_RVALID)
		else $error("read not answered next cycle");
	a_read_zero_bits: assert property (SR_RD |=> SR_RDATA[27:6] == 0)
		else $error("reserved or state bits read nonzero");
	a_entry_handler: assert property (s_entry |=> HANDLER_MODE &&
		EXC_NUMBER == $past(EXC_ENTRY_NUM) && !SP_USE_PROCESS)
		else $error("entry did not reach handler state");
	a_entry_reject: assert property (EXC_ENTRY && rsv_num |=> ENTRY_REJECT)
		else $error("reserved entry number not rejected");
	a_handler_main: assert property (HANDLER_MODE |-> !SP_USE_PROCESS)
		else $error("handler on process stack");
	a_handler_priv: assert property (HANDLER_MODE |-> PRIVILEGED)
		else $error("handler not privileged");
	a_vector_tbit: assert property (RST_VEC_VALID |=>
		TBIT == $past(RST_VEC_WORD[0]))
		else $error("state bit not loaded from vector");
	a_xchg_clear: assert property (XCHG_BRANCH && !XCHG_TARGET_BIT0 &&
		!RST_VEC_VALID && !EXC_ENTRY && !EXC_RETURN |=> !TBIT)
		else $error("exchange branch kept state bit");
	a_fault_clear: assert property (EXEC_ATTEMPT && !TBIT &&
		!HANDLER_MODE |=> FAULT_REQ)
		else $error("no fault on clear state bit");
	a_lockup_hold: assert property (LOCKUP |=> LOCKUP)
		else $error("lockup released without reset");
	a_irq_abandon: assert property (IRQ_TAKE && (MULTI_BUSY || MUL_BUSY)
		|=> ABANDON)
		else $error("busy instruction not abandoned");
	a_mask_change: assert property (CPS_EN && PRIVILEGED |=>
		CFG_EXC_BLOCK == $past(CPS_MASK))
		else $error("mask change not applied");
	a_unpriv_lock: assert property (s_unpriv_ctrl |=>
		$stable(SP_USE_PROCESS) && $stable(PRIVILEGED))
		else $error("unprivileged control write took effect");
	a_instr_little: assert property (!INSTR_BIG_ENDIAN)
		else $error("instruction order not little-endian");
endmodule : csc_regs_sva

bind csc_regs csc_regs_sva #(
	.HAS_SYSTEM_TICK_EXCEPTION(HAS_SYSTEM_TICK_EXCEPTION),
	.NUM_IRQ    (NUM_IRQ)
) u_sva (.*);

`default_nettype wire

// ### bench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_top;
	logic CLK, NRST, SR_RD, SR_WR, CPS_EN, CPS_MASK, FLAGS_WE, RST_VEC_VALID;
	logic EXC_ENTRY, EXC_VEC_BIT0, EXC_RETURN, RET_TO_THREAD, RET_STACK_SELECT;
	logic RET_STACKED_T, XCHG_BRANCH, XCHG_TARGET_BIT0, EXEC_ATTEMPT;
	logic MULTI_BUSY, MUL_BUSY, IRQ_TAKE, SR_RVALID, TBIT, ENTRY_REJECT;
	logic HANDLER_MODE, PRIVILEGED, SP_USE_PROCESS, CFG_EXC_BLOCK;
	logic FAULT_REQ, LOCKUP, ABANDON, DATA_BIG_ENDIAN, INSTR_BIG_ENDIAN;
	logic [7:0]  SR_SEL;
	logic [31:0] SR_WDATA, RST_VEC_WORD, SR_RDATA, STACKED_PSR;
	logic [3:0]  FLAGS_IN, RET_STACKED_FLAGS, FLAGS;
	logic [5:0]  EXC_ENTRY_NUM, RET_EXC_NUM, EXC_NUMBER;
	int          mismatches = 0;
	int          tests_run = 0;
	logic [31:0] rv;

	// Smaller interrupt count and no tick timer, so both limits are reachable
	csc_regs #(.HAS_SYSTEM_TICK_EXCEPTION(1'b0), .NUM_IRQ(8)) DUT (.*);

	// Clock and watchdog
	initial
	begin
		CLK = 1'b0;
		forever #2 CLK = ~CLK;
	end
	initial
	begin
		repeat (5000) @(posedge CLK);
		mismatches++;
		wrap_up();
	end

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : wrap_up

	task automatic chk(input string what, input logic [31:0] exp, got);
		tests_run++;
		if (got !== exp)
		begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// Each request is raised at a falling edge and taken at the next rise
	task automatic wr(input logic [7:0] s, input logic [31:0] d);
		SR_WR = 1'b1; SR_SEL = s; SR_WDATA = d;
		@(negedge CLK);
		SR_WR = 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] s, output logic [31:0] d);
		SR_RD = 1'b1; SR_SEL = s;
		@(negedge CLK);
		SR_RD = 1'b0;
		chk("read valid", 1, SR_RVALID);
		d = SR_RDATA;
	endtask : rd
	task automatic enter(input logic [5:0] n, input logic v0);
		EXC_ENTRY = 1'b1; EXC_ENTRY_NUM = n; EXC_VEC_BIT0 = v0;
		@(negedge CLK);
		EXC_ENTRY = 1'b0;
	endtask : enter
	task automatic leave(input logic sp, t, input logic [3:0] f);
		EXC_RETURN = 1'b1; RET_TO_THREAD = 1'b1; RET_EXC_NUM = 6'h00;
		RET_STACK_SELECT = sp; RET_STACKED_T = t; RET_STACKED_FLAGS = f;
		@(negedge CLK);
		EXC_RETURN = 1'b0;
	endtask : leave

	task automatic t_reset();
		chk("priv", 1, PRIVILEGED);
		chk("sp", 0, SP_USE_PROCESS);
		chk("exc", 0, EXC_NUMBER);
		chk("endian", 0, {DATA_BIG_ENDIAN, INSTR_BIG_ENDIAN});
		RST_VEC_VALID = 1'b1; RST_VEC_WORD = 32'h0000_0101;
		@(negedge CLK);
		RST_VEC_VALID = 1'b0;
		chk("tbit", 1, TBIT);
	endtask : t_reset

	task automatic t_flags();
		wr(csc_pkg::SEL_FLAGS, 32'hFFFF_FFFF);
		rd(csc_pkg::SEL_FLAGS, rv);
		chk("flag view", 32'hF000_0000, rv);
		FLAGS_WE = 1'b1; FLAGS_IN = 4'h5;
		@(negedge CLK);
		FLAGS_WE = 1'b0;
		chk("alu flags", 4'h5, FLAGS);
		wr(csc_pkg::SEL_STATE, 32'h0000_0000);
		chk("tbit kept", 1, TBIT);
	endtask : t_flags

	task automatic t_control();
		wr(csc_pkg::SEL_CONTROL, 32'hFFFF_FFFE);
		chk("sp proc", 1, SP_USE_PROCESS);
		wr(csc_pkg::SEL_CONTROL, 32'h0000_0003);
		chk("unpriv", 0, PRIVILEGED);
		rd(csc_pkg::SEL_CONTROL, rv);
		chk("ctrl rd", 3, rv);
		wr(csc_pkg::SEL_CONTROL, 32'h0000_0000);
		CPS_EN = 1'b1; CPS_MASK = 1'b1;
		@(negedge CLK);
		CPS_EN = 1'b0;
		chk("locked", 2'b10, {SP_USE_PROCESS, PRIVILEGED});
		chk("no mask", 0, CFG_EXC_BLOCK);
	endtask : t_control

	task automatic t_handler();
		logic [7:0]  sels [8] = '{8'h00, 8'h01, 8'h02, 8'h03,
			8'h05, 8'h06, 8'h07, 8'h20};
		logic [31:0] exps [8] = '{32'h5000_0000, 32'h5000_0010,
			32'h5000_0000, 32'h5000_0010, 32'h0000_0010, 32'h0000_0000,
			32'h0000_0010, 32'h0000_0000};
		enter(6'h10, 1'b1);
		chk("hmode", 3'b110, {HANDLER_MODE, PRIVILEGED, SP_USE_PROCESS});
		chk("exc", 6'h10, EXC_NUMBER);
		chk("stacked", 32'h5100_0000, STACKED_PSR);
		for (int i = 0; i < 8; i++)
		begin
			rd(sels[i], rv);
			chk("view", exps[i], rv);
		end
		wr(csc_pkg::SEL_COMBINED, 32'hA000_003F);
		chk("exc kept", 6'h10, EXC_NUMBER);
		chk("flags set", 4'hA, FLAGS);
		rd(csc_pkg::SEL_CONTROL, rv);
		chk("ctrl hnd", 1, rv);
		wr(csc_pkg::SEL_CONTROL, 32'h0000_0002);
		rd(csc_pkg::SEL_CONTROL, rv);
		chk("ctrl hnd wr", 0, rv);
		leave(1'b1, 1'b1, 4'h3);
		chk("ret", 3'b011, {HANDLER_MODE, PRIVILEGED, SP_USE_PROCESS});
		chk("ret flags", 4'h3, FLAGS);
	endtask : t_handler

	task automatic t_mask();
		CPS_EN = 1'b1; CPS_MASK = 1'b1;
		@(negedge CLK);
		CPS_EN = 1'b0;
		chk("mask on", 1, CFG_EXC_BLOCK);
		rd(csc_pkg::SEL_PRIORITY_MASK, rv);
		chk("mask rd", 1, rv);
		wr(csc_pkg::SEL_PRIORITY_MASK, 32'hFFFF_FFFE);
		rd(csc_pkg::SEL_PRIORITY_MASK, rv);
		chk("mask off", 0, rv);
	endtask : t_mask

	task automatic t_codes();
		logic [5:0] codes [11] = '{0, 1, 4, 15, 24, 48, 2, 3, 11, 14, 23};
		for (int i = 0; i < 11; i++)
		begin
			enter(codes[i], 1'b1);
			chk("reject", i < 6, ENTRY_REJECT);
			chk("exc num", (i < 6) ? 6'h00 : codes[i], EXC_NUMBER);
			if (i >= 6)
				leave(1'b0, 1'b1, 4'h0);
		end
	endtask : t_codes

	task automatic t_state();
		XCHG_BRANCH = 1'b1; XCHG_TARGET_BIT0 = 1'b0;
		@(negedge CLK);
		XCHG_BRANCH = 1'b0;
		chk("xchg", 0, TBIT);
		EXEC_ATTEMPT = 1'b1;
		@(negedge CLK);
		EXEC_ATTEMPT = 1'b0;
		chk("fault", 2'b10, {FAULT_REQ, LOCKUP});
		XCHG_BRANCH = 1'b1; XCHG_TARGET_BIT0 = 1'b1;
		@(negedge CLK);
		XCHG_BRANCH = 1'b0;
		enter(6'h03, 1'b0);
		chk("vec clr", 0, TBIT);
		EXEC_ATTEMPT = 1'b1;
		@(negedge CLK);
		EXEC_ATTEMPT = 1'b0;
		repeat (3) @(negedge CLK);
		chk("lockup", 1, LOCKUP);
		NRST = 1'b0;
		repeat (2) @(negedge CLK);
		NRST = 1'b1;
		chk("rst again", 2'b01, {LOCKUP, PRIVILEGED});
	endtask : t_state

	task automatic t_abandon();
		for (int i = 0; i < 3; i++)
		begin
			MULTI_BUSY = (i == 0); MUL_BUSY = (i == 1); IRQ_TAKE = 1'b1;
			@(negedge CLK);
			IRQ_TAKE = 1'b0;
			chk("abandon", i < 2, ABANDON);
		end
	endtask : t_abandon

	// Inputs start quiet; reset is held for eight cycles
	initial
	begin
		{SR_RD, SR_WR, CPS_EN, CPS_MASK, FLAGS_WE, RST_VEC_VALID} = '0;
		{EXC_ENTRY, EXC_VEC_BIT0, EXC_RETURN, RET_TO_THREAD, RET_STACK_SELECT} = '0;
		{RET_STACKED_T, XCHG_BRANCH, XCHG_TARGET_BIT0, EXEC_ATTEMPT} = '0;
		{MULTI_BUSY, MUL_BUSY, IRQ_TAKE, SR_SEL, SR_WDATA} = '0;
		{RST_VEC_WORD, FLAGS_IN, RET_STACKED_FLAGS} = '0;
		{EXC_ENTRY_NUM, RET_EXC_NUM} = '0;
		NRST = 1'b0;
		repeat (8) @(negedge CLK);
		NRST = 1'b1;
		t_reset();
		t_flags();
		t_control();
		t_handler();
		t_mask();
		t_codes();
		t_abandon();
		t_state();
		wrap_up();
	end
endmodule : tb_top

`default_nettype wire
